//--- hw/flic_defines.vh
`ifndef FLIC_DEFINES_VH
`define FLIC_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FLIC_ADDR_IRQ_ENABLE 8'ha8
`define FLIC_ADDR_PRIORITY_LOW 8'hb8
`define FLIC_ADDR_PRIORITY_HIGH 8'hb7
`define FLIC_ADDR_STATUS 8'hc0
`define FLIC_ADDR_MASK 8'hc1
`define FLIC_ADDR_BIT_OP 8'hc2
`define FLIC_ADDR_IN_SERVICE 8'hc3

// ----------------------------------------
// Field positions and sizes
// ----------------------------------------
`define FLIC_NSRC 7
`define FLIC_GLOBAL_BIT 7
`define FLIC_IRQ_ENABLE_RESET 8'h00
`define FLIC_PRIORITY_RESET 8'h00
`define FLIC_PRIORITY_USED 8'h7f
`define FLIC_BITOP_SEL_REG 4
`define FLIC_BITOP_VALUE 3
`define FLIC_EVT_VECTOR 0
`define FLIC_EVT_RETURN 1

// ----------------------------------------
// Vector addresses
// ----------------------------------------
`define FLIC_VEC_EXT0 16'h0003
`define FLIC_VEC_TIMER0 16'h000b
`define FLIC_VEC_EXT1 16'h0013
`define FLIC_VEC_TIMER1 16'h001b
`define FLIC_VEC_SERIAL 16'h0023
`define FLIC_VEC_TIMER2 16'h002b
`define FLIC_VEC_COUNTER_ARRAY 16'h0033

`endif

//--- hw/flic_sync.v
`timescale 1ns/1ps
module flic_sync (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Pins
  input wire [1:0] pin_in,
  // Synchronised
  output reg [1:0] pin_sync
);

reg [1:0] pin_meta;

always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    pin_meta <= 2'h3;
    pin_sync <= 2'h3;
  end else begin
    pin_meta <= pin_in;
    pin_sync <= pin_meta;
  end
end

endmodule

//--- hw/flic_arbiter.v
`timescale 1ns/1ps
`include "flic_defines.vh"
module flic_arbiter (
  // Requests and levels
  input wire [6:0] req,
  input wire [6:0] lvl_low,
  input wire [6:0] lvl_high,
  // Winner
  output reg found,
  output reg [2:0] win_idx,
  output reg [1:0] win_lvl
);

integer i;
reg [1:0] l;

// Index order is the polling order, so the lowest index wins a tie
always @* begin
  found = 1'b0;
  win_idx = 3'h0;
  win_lvl = 2'h0;
  l = 2'h0;
  for (i = `FLIC_NSRC - 1; i >= 0; i = i - 1) begin
    l = {lvl_high[i], lvl_low[i]};
    if (req[i] && (!found || l >= win_lvl)) begin
      found = 1'b1;
      win_idx = i[2:0];
      win_lvl = l;
    end
  end
end

endmodule

//--- hw/flic_top.v
// Contract
// - Seven request sources, each own vector
// - Poll order ext0,t0,ext1,t1,serial,t2,counter
// - Forward only with own and global enable
// - Global enable clear blocks every source
// - Each source gets one of four levels
// - Level is high bit over low bit
// - Preempt only by strictly higher level
// - Level three service blocks all others
// - Different levels together: higher served first
// - Same level together: fixed polling decides
// - Counter array vector is 0033h
// - Enable bits: global, counter, t2..ext0
// - Enable resets zero, single bit operations
// - Low priority bits 6..0, reset zero
// - Low and high bits pair per source
`timescale 1ns/1ps
`include "flic_defines.vh"
module flic_top (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // External request pins, active low
  input wire ext_request0_pin_n,
  input wire ext_request1_pin_n,
  // Peripheral flags, same clock
  input wire timer0_overflow_flag,
  input wire timer1_overflow_flag,
  input wire timer2_overflow_flag,
  input wire timer2_external_flag,
  input wire receive_done_flag,
  input wire transmit_done_flag,
  input wire counter_array_flag,
  // Core handshake
  output wire irq_req,
  output reg [15:0] irq_vector,
  output reg [1:0] irq_level,
  input wire irq_ack,
  input wire irq_return,
  // Controller interrupt
  output wire irq_out
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] irq_enable_reg;
reg [7:0] priority_low_reg;
reg [7:0] priority_high_reg;
reg [3:0] in_service;
reg [1:0] status_reg;
reg [1:0] mask_reg;
wire [1:0] ext_sync;
wire [6:0] raw_req;
wire [6:0] gated_req;
wire found;
wire [2:0] win_idx;
wire [1:0] win_lvl;
wire wr_hit;
reg [3:0] next_in_service;
reg preempt_ok;
wire take;
wire ret;
wire bitop;
wire [2:0] bit_pos;
wire [1:0] bit_reg;

// ----------------------------------------
// Functions
// ----------------------------------------
function [15:0] vec_of;
  input [2:0] idx;
  begin
    case (idx)
      3'h0: vec_of = `FLIC_VEC_EXT0;
      3'h1: vec_of = `FLIC_VEC_TIMER0;
      3'h2: vec_of = `FLIC_VEC_EXT1;
      3'h3: vec_of = `FLIC_VEC_TIMER1;
      3'h4: vec_of = `FLIC_VEC_SERIAL;
      3'h5: vec_of = `FLIC_VEC_TIMER2;
      default: vec_of = `FLIC_VEC_COUNTER_ARRAY;
    endcase
  end
endfunction

function [7:0] set_bit;
  input [7:0] val;
  input [2:0] pos;
  input b;
  reg [7:0] m;
  begin
    m = 8'h01 << pos;
    set_bit = b ? (val | m) : (val & ~m);
  end
endfunction

// Highest in-service level plus one (zero when none is set), for the preemption check
function [2:0] top_level;
  input [3:0] v;
  begin
    if (v[3]) top_level = 3'h4;
    else if (v[2]) top_level = 3'h3;
    else if (v[1]) top_level = 3'h2;
    else if (v[0]) top_level = 3'h1;
    else top_level = 3'h0;
  end
endfunction

// ----------------------------------------
// Request sources
// ----------------------------------------
flic_sync u_sync (
  .clk(clk),
  .rstn(rstn),
  .pin_in({ext_request1_pin_n, ext_request0_pin_n}),
  .pin_sync(ext_sync)
);

// Polling order is fixed by bit index
assign raw_req = {counter_array_flag,
                  timer2_overflow_flag | timer2_external_flag,
                  receive_done_flag | transmit_done_flag,
                  timer1_overflow_flag,
                  ~ext_sync[1],
                  timer0_overflow_flag,
                  ~ext_sync[0]};

assign gated_req = irq_enable_reg[`FLIC_GLOBAL_BIT] ?
                   (raw_req & irq_enable_reg[6:0]) : 7'h00;

flic_arbiter u_arb (
  .req(gated_req),
  .lvl_low(priority_low_reg[6:0]),
  .lvl_high(priority_high_reg[6:0]),
  .found(found),
  .win_idx(win_idx),
  .win_lvl(win_lvl)
);

// ----------------------------------------
// Preemption
// ----------------------------------------
always @* begin
  preempt_ok = 1'b1;
  if (in_service[3]) begin
    preempt_ok = 1'b0;
  end else if (top_level(in_service) != 3'h0) begin
    // Stored level plus one must stay below the candidate's level plus one
    preempt_ok = ({1'b0, win_lvl} + 3'h1) > top_level(in_service);
  end
end

assign irq_req = found & preempt_ok;
assign take = irq_req & irq_ack;
assign ret = irq_return & (in_service != 4'h0);

// Return drops only the top level, restoring the one beneath it
always @* begin
  next_in_service = in_service;
  if (ret) begin
    next_in_service = in_service;
    if (in_service[3]) next_in_service[3] = 1'b0;
    else if (in_service[2]) next_in_service[2] = 1'b0;
    else if (in_service[1]) next_in_service[1] = 1'b0;
    else next_in_service[0] = 1'b0;
  end
  if (take) begin
    next_in_service = next_in_service | (4'h1 << win_lvl);
  end
end

always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    in_service <= 4'h0;
    irq_vector <= 16'h0000;
    irq_level <= 2'h0;
  end else begin
    in_service <= next_in_service;
    irq_vector <= vec_of(win_idx);
    irq_level <= win_lvl;
  end
end

// ----------------------------------------
// Register writes
// ----------------------------------------
assign wr_hit = reg_wr;
assign bitop = reg_wr && (reg_addr == `FLIC_ADDR_BIT_OP);
assign bit_pos = reg_wdata[2:0];
assign bit_reg = reg_wdata[`FLIC_BITOP_SEL_REG + 1:`FLIC_BITOP_SEL_REG];

always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    irq_enable_reg <= `FLIC_IRQ_ENABLE_RESET;
    priority_low_reg <= `FLIC_PRIORITY_RESET;
    priority_high_reg <= `FLIC_PRIORITY_RESET;
    mask_reg <= 2'h0;
  end else if (wr_hit) begin
    if (reg_addr == `FLIC_ADDR_IRQ_ENABLE) begin
      irq_enable_reg <= reg_wdata;
    end else if (reg_addr == `FLIC_ADDR_PRIORITY_LOW) begin
      // Bit 7 is held at zero so a stray write cannot alter levels
      priority_low_reg <= reg_wdata & `FLIC_PRIORITY_USED;
    end else if (reg_addr == `FLIC_ADDR_PRIORITY_HIGH) begin
      priority_high_reg <= reg_wdata & `FLIC_PRIORITY_USED;
    end else if (reg_addr == `FLIC_ADDR_MASK) begin
      mask_reg <= reg_wdata[1:0];
    end else if (bitop) begin
      // Single-bit set or clear touches only the addressed bit
      if (bit_reg == 2'h0) begin
        irq_enable_reg <= set_bit(irq_enable_reg, bit_pos,
                                  reg_wdata[`FLIC_BITOP_VALUE]);
      end else if (bit_reg == 2'h1) begin
        priority_low_reg <= set_bit(priority_low_reg, bit_pos,
                                    reg_wdata[`FLIC_BITOP_VALUE]) &
                            `FLIC_PRIORITY_USED;
      end else if (bit_reg == 2'h2) begin
        priority_high_reg <= set_bit(priority_high_reg, bit_pos,
                                     reg_wdata[`FLIC_BITOP_VALUE]) &
                             `FLIC_PRIORITY_USED;
      end
    end
  end
end

// ----------------------------------------
// Event status, write one to clear
// ----------------------------------------
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    status_reg <= 2'h0;
  end else begin
    // Set wins over a clear in the same cycle
    status_reg <= (status_reg &
                   ~((wr_hit && reg_addr == `FLIC_ADDR_STATUS) ? reg_wdata[1:0] : 2'h0))
                  | {ret, take};
  end
end

assign irq_out = |(status_reg & mask_reg);

// ----------------------------------------
// Register reads
// ----------------------------------------
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    reg_rdata <= 8'h00;
  end else if (reg_rd) begin
    if (reg_addr == `FLIC_ADDR_IRQ_ENABLE) begin
      reg_rdata <= irq_enable_reg;
    end else if (reg_addr == `FLIC_ADDR_PRIORITY_LOW) begin
      reg_rdata <= priority_low_reg;
    end else if (reg_addr == `FLIC_ADDR_PRIORITY_HIGH) begin
      reg_rdata <= priority_high_reg;
    end else if (reg_addr == `FLIC_ADDR_STATUS) begin
      reg_rdata <= {6'h00, status_reg};
    end else if (reg_addr == `FLIC_ADDR_MASK) begin
      reg_rdata <= {6'h00, mask_reg};
    end else if (reg_addr == `FLIC_ADDR_IN_SERVICE) begin
      reg_rdata <= {4'h0, in_service};
    end else begin
      reg_rdata <= 8'h00;
    end
  end
end

endmodule

//--- testbench/flic_properties.sv
`timescale 1ns/1ps
module flic_properties (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Core side
  input wire irq_req,
  input wire [15:0] irq_vector,
  input wire [1:0] irq_level,
  input wire irq_ack,
  input wire irq_return,
  input wire irq_out
);
  reg [7:0] en;
  reg [7:0] msk;
  reg top3;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----
  // Shadows
  // ----
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en <= 8'h00;
      msk <= 8'h00;
      top3 <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'ha8)
        en <= reg_wdata;
      if (reg_wr && reg_addr == 8'hc2 && reg_wdata[5:4] == 2'h0)
        en[reg_wdata[2:0]] <= reg_wdata[3];
      if (reg_wr && reg_addr == 8'hc1)
        msk <= reg_wdata;
      // Nothing nests above level 3, so the next return always ends it
      if (irq_ack && irq_req && irq_level == 2'h3)
        top3 <= 1'b1;
      else if (irq_return)
        top3 <= 1'b0;
    end
  end
  // ----
  // Checks
  // ----
  a_global_gate: assert property (!en[7] |-> !irq_req)
    else $error("request while globally off");
  a_source_gate: assert property (en[6:0] == 7'h00 |-> !irq_req)
    else $error("request with no source on");
  a_top_blocks: assert property (top3 |-> !irq_req)
    else $error("request during level 3");
  a_enable_back: assert property (reg_rd && reg_addr == 8'ha8 |=> reg_rdata == en)
    else $error("enable readback");
  a_spare_zero: assert property (reg_rd && reg_addr == 8'hb8 |=> !reg_rdata[7])
    else $error("low priority bit 7 set");
  a_vector_legal: assert property ($rose(irq_req) |=>
    irq_vector[2:0] == 3'h3 && irq_vector < 16'h0034)
    else $error("illegal vector");
  a_mask_quiet: assert property (msk == 8'h00 |-> !irq_out)
    else $error("masked interrupt out");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind flic_top flic_properties i_flic_properties (.*);

//--- testbench/flic_core_model.sv
`timescale 1ns/1ps
module flic_core_model (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Controller side
  input wire irq_req,
  input wire [15:0] irq_vector,
  output reg irq_ack,
  output reg irq_return,
  // Bench side
  input wire ret_cmd,
  output reg [15:0] taken_vec,
  output reg taken
);
  reg seen;
  // Ack one cycle late so the registered vector has settled
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      seen <= 1'b0;
      taken_vec <= 16'h0000;
      taken <= 1'b0;
    end else begin
      seen <= irq_req && !irq_ack;
      irq_ack <= irq_req && seen && !irq_ack;
      taken <= irq_ack && irq_req;
      if (irq_ack && irq_req)
        taken_vec <= irq_vector;
      irq_return <= ret_cmd;
    end
  end
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [6:0] src = 7'h00;
  reg ret_cmd = 1'b0;
  reg [3:0] i;
  wire [7:0] reg_rdata;
  wire irq_req, irq_ack, irq_return, irq_out, taken;
  wire [15:0] irq_vector, taken_vec;
  wire [1:0] irq_level;
  integer err_count = 0;
  integer comparisons = 0;
  always #50 clk = ~clk;
  flic_top i_flic_top (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_request0_pin_n(~src[0]), .ext_request1_pin_n(~src[2]),
    .timer0_overflow_flag(src[1]), .timer1_overflow_flag(src[3]),
    .timer2_overflow_flag(src[5]), .timer2_external_flag(src[5]),
    .receive_done_flag(src[4]), .transmit_done_flag(src[4]), .counter_array_flag(src[6]),
    .irq_req, .irq_vector, .irq_level, .irq_ack, .irq_return, .irq_out);
  flic_core_model i_flic_core_model (.clk, .rstn, .irq_req, .irq_vector, .irq_ack,
    .irq_return, .ret_cmd, .taken_vec, .taken);
  task conclude;
    begin
      if (err_count == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task check(input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check({8'h00, reg_rdata}, {8'h00, e});
    end
  endtask
  task quiet;
    begin
      repeat (4) @(posedge clk);
      #1;
      check({15'h0000, irq_req}, 16'h0000);
    end
  endtask
  task take(input [15:0] e);
    integer n;
    begin
      n = 0;
      while (taken !== 1'b1 && n < 50) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      if (n == 50) begin
        err_count = err_count + 1;
        conclude;
      end else begin
        check(taken_vec, e);
      end
    end
  endtask
  task ret;
    begin
      repeat (2) @(posedge clk);
      ret_cmd <= 1'b1;
      @(posedge clk);
      ret_cmd <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(8'ha8, 8'h00);
    rd(8'hb8, 8'h00);
    rd(8'hb7, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'hb8, 8'h7f);
    rd(8'hb8, 8'h7f);
    wr(8'hb8, 8'h00);
    wr(8'hc2, 8'h0f);
    wr(8'hc2, 8'h08);
    rd(8'ha8, 8'h81);
    wr(8'hc2, 8'h07);
    rd(8'ha8, 8'h01);
    src <= 7'h7f;
    wr(8'ha8, 8'h80);
    quiet;
    wr(8'ha8, 8'h7f);
    quiet;
    wr(8'hc0, 8'hff);
    wr(8'hc1, 8'h01);
    wr(8'ha8, 8'hff);
    // Vectors sit eight apart from 0003h in polling order
    for (i = 4'h0; i < 4'h7; i = i + 4'h1) begin
      take(16'h0003 + 16'h0008 * i);
      src[i] <= 1'b0;
      ret;
    end
    check({15'h0000, irq_out}, 16'h0001);
    rd(8'hc0, 8'h03);
    wr(8'hc0, 8'h03);
    check({15'h0000, irq_out}, 16'h0000);
    wr(8'hb8, 8'h01);
    wr(8'hb7, 8'h40);
    src <= 7'h4b;
    take(16'h0033);
    src[6] <= 1'b0;
    quiet;
    // Winner level is still shown while preemption holds it back
    check({14'h0000, irq_level}, 16'h0001);
    wr(8'hb7, 8'h42);
    quiet;
    check({14'h0000, irq_level}, 16'h0002);
    wr(8'hb8, 8'h03);
    take(16'h000b);
    src[1] <= 1'b0;
    quiet;
    ret;
    quiet;
    ret;
    take(16'h0003);
    src[0] <= 1'b0;
    ret;
    take(16'h001b);
    src[3] <= 1'b0;
    ret;
    conclude;
  end
endmodule
